/* File: rtl/pbe_event_count.sv */
// event counter top: event select, counting and Avalon-MM register slave
// Notes on behaviour
// RQ1: event 4b/01 counts executed all-levels prefetch hints missing every cache.
// RQ2: event 4b/02 counts executed outer-level prefetch hints, either variant, missing all.
// RQ3: prefetch misses count at execution, so squashed speculative ones still count.
// RQ4: event 4c/00 counts loads hitting a line whose software prefetch is unfinished.
// RQ5: event 4e/10 counts every first-level prefetch request, rejected ones too.
// RQ6: first-level prefetch requests are refused while second-level cache is busy.
// RQ7: event 60 adds the number of pending full-line reads each cycle.
// RQ8: a read is pending from its issue until the whole line arrives.
// RQ9: only full-line cacheable first-level or second-level prefetch reads count as pending.
// RQ10: event 61 counts each hold-off assertion this device drives.
// RQ11: hold-off is asserted when outstanding data and snoop work nears the limit.
// RQ12: each hold-off assertion lasts two bus cycles.
// RQ13: no new transaction is issued while hold-off is asserted.
// RQ14: event 62 counts cycles with the data-valid strobe asserted.
// RQ15: the data-driving agent asserts the data-valid strobe every transfer cycle.
// RQ16: own-agent mask counts only cycles this device drives data.
// RQ17: any-agent mask counts every cycle any agent drives data.
// RQ18: code and mask must match exactly; counter adds occurrences per cycle.
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defines.svh"
module pbe_event_count
    import pbe_pkg::*;
#(
    parameter int PF_SLOTS = `PBE_PF_SLOTS
) (
    input wire logic ref_clk,
    input wire logic nrst,

    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,

    input wire logic pfExec,
    input wire logic [1:0] pfKind,
    input wire logic pfMissAll,
    input wire logic pfStart,
    input wire logic [`PBE_LINE_W-1:0] pfStartLine,
    input wire logic pfDone,
    input wire logic [`PBE_LINE_W-1:0] pfDoneLine,
    input wire logic loadIssue,
    input wire logic [`PBE_LINE_W-1:0] loadLine,
    input wire logic l1PfReq,
    input wire logic l2Busy,
    output logic l1PfAccept,

    input wire logic coreBusReq,
    output logic busReqGo,
    input wire logic busIssue,
    input wire logic [2:0] busIssueKind,
    input wire logic busLineDone,
    input wire logic [2:0] busDoneKind,
    input wire logic dataValidIn,
    input wire logic holdOffIn,
    input wire logic [`PBE_PEND_W-1:0] snoopPend,
    input wire logic ownDataXfer,
    output logic dataValidOut,
    output logic holdOffOut
);
    pbe_evt_if evt ();

    pbe_top_st_t st_ff, nxt_st;
    logic [7:0] evCode;
    logic [7:0] evMask;
    logic [7:0] inc;
    logic issueOk;
    logic req;
    logic hit;

    // ==================================================
    // detectors
    pbe_pf_track #(
        .SLOTS(PF_SLOTS)
    ) u_track (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .pfStart(pfStart),
        .pfStartLine(pfStartLine),
        .pfDone(pfDone),
        .pfDoneLine(pfDoneLine),
        .loadIssue(loadIssue),
        .loadLine(loadLine),
        .evt(evt.trk)
    );

    pbe_bus_mon u_bus (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .busIssue(busIssue),
        .busIssueKind(busIssueKind),
        .busLineDone(busLineDone),
        .busDoneKind(busDoneKind),
        .dataValidIn(dataValidIn),
        .holdOffIn(holdOffIn),
        .snoopPend(snoopPend),
        .ownDataXfer(ownDataXfer),
        .dataValidOut(dataValidOut),
        .holdOffOut(holdOffOut),
        .issueOk(issueOk),
        .evt(evt.bus)
    );

    // ==================================================
    // helpers
    function automatic logic selIs(input logic [7:0] c, input logic [7:0] m,
                                   input logic [7:0] wc, input logic [7:0] wm);
        selIs = (c == wc) && (m == wm); // RQ18
    endfunction

    function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        byteMerge = r;
    endfunction

    assign l1PfAccept = l1PfReq && !l2Busy; // RQ6
    assign busReqGo = coreBusReq && issueOk; // RQ13

    // ==================================================
    // event select
    assign evCode = st_ff.ctrl[`PBE_CTRL_EVT_LSB +: 8];
    assign evMask = st_ff.ctrl[`PBE_CTRL_UM_LSB +: 8];

    always_comb begin
        inc = 8'h00;
        // execution-time qualification: no retire input exists, squashed prefetches still count
        if (selIs(evCode, evMask, `PBE_EV_PF_MISS, `PBE_UM_PF_ALL)) begin
            inc = {7'h00, pfExec && pfMissAll && pfKind == PBE_PF_ALL}; // RQ1 RQ3
        end else if (selIs(evCode, evMask, `PBE_EV_PF_MISS, `PBE_UM_PF_OUTER)) begin
            inc = {7'h00, pfExec && pfMissAll
                && (pfKind == PBE_PF_OUTER_A || pfKind == PBE_PF_OUTER_B)}; // RQ2 RQ3
        end else if (selIs(evCode, evMask, `PBE_EV_LOAD_HIT_PF, `PBE_UM_LOAD_HIT_PF)) begin
            inc = {7'h00, evt.loadHitPf}; // RQ4
        end else if (selIs(evCode, evMask, `PBE_EV_L1_PF_REQ, `PBE_UM_L1_PF_REQ)) begin
            inc = {7'h00, l1PfReq}; // RQ5
        end else if (selIs(evCode, evMask, `PBE_EV_RD_PEND, `PBE_UM_THIS_AGENT)) begin
            inc = {{(8-`PBE_PEND_W){1'b0}}, evt.pendOcc}; // RQ7
        end else if (selIs(evCode, evMask, `PBE_EV_NOT_READY, `PBE_UM_THIS_AGENT)) begin
            inc = {7'h00, evt.notReadyRise}; // RQ10 RQ12
        end else if (selIs(evCode, evMask, `PBE_EV_DATA_VALID, `PBE_UM_THIS_AGENT)) begin
            inc = {7'h00, evt.dvOwn}; // RQ14 RQ16
        end else if (selIs(evCode, evMask, `PBE_EV_DATA_VALID, `PBE_UM_ALL_AGENTS)) begin
            inc = {7'h00, evt.dvAny}; // RQ14 RQ17
        end
    end

    // ==================================================
    // register slave and counter
    // one wait state on every access: the answer edge is the second edge of the request
    assign req = avs_read || avs_write;
    assign hit = req && st_ff.ack;
    assign avs_waitrequest = req && !st_ff.ack;
    assign avs_readdata = st_ff.rdata;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = req && !st_ff.ack;
        if (st_ff.ctrl[`PBE_CTRL_EN_BIT]) begin
            nxt_st.count = st_ff.count + {24'h000000, inc}; // RQ18
        end
        if (req && !st_ff.ack) begin
            unique case (avs_address)
                `PBE_OFS_CTRL: nxt_st.rdata = {15'h0000, st_ff.ctrl};
                `PBE_OFS_COUNT: nxt_st.rdata = st_ff.count;
                `PBE_OFS_STATUS: nxt_st.rdata = {23'h000000, evt.holdOffOut,
                    {(8-`PBE_PEND_W){1'b0}}, evt.pendNow};
                default: nxt_st.rdata = 32'h00000000;
            endcase
        end
        // a software write to the count wins over the increment of the same cycle
        if (hit && avs_write) begin
            if (avs_address == `PBE_OFS_CTRL) begin
                nxt_st.ctrl = 17'(byteMerge({15'h0000, st_ff.ctrl}, avs_writedata, avs_byteenable));
            end else if (avs_address == `PBE_OFS_COUNT) begin
                nxt_st.count = byteMerge(st_ff.count, avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff.ctrl <= `PBE_CTRL_RST;
            st_ff.count <= `PBE_COUNT_RST;
            st_ff.ack <= 1'b0;
            st_ff.rdata <= 32'h00000000;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule
`default_nettype wire

/* File: pkg/pbe_defines.svh */
// offsets, field positions, reset values and counts for the prefetch/bus event counter
`ifndef PBE_DEFINES_SVH
`define PBE_DEFINES_SVH

// ==================================================
// register map (byte offsets)
`define PBE_OFS_CTRL 4'h0
`define PBE_OFS_COUNT 4'h4
`define PBE_OFS_STATUS 4'h8

// ==================================================
// control fields
`define PBE_CTRL_EVT_LSB 0
`define PBE_CTRL_UM_LSB 8
`define PBE_CTRL_EN_BIT 16
`define PBE_CTRL_RST 17'h00000
`define PBE_COUNT_RST 32'h00000000

// ==================================================
// event codes and unit masks
`define PBE_EV_PF_MISS 8'h4b
`define PBE_UM_PF_ALL 8'h01
`define PBE_UM_PF_OUTER 8'h02
`define PBE_EV_LOAD_HIT_PF 8'h4c
`define PBE_UM_LOAD_HIT_PF 8'h00
`define PBE_EV_L1_PF_REQ 8'h4e
`define PBE_UM_L1_PF_REQ 8'h10
`define PBE_EV_RD_PEND 8'h60
`define PBE_EV_NOT_READY 8'h61
`define PBE_EV_DATA_VALID 8'h62
`define PBE_UM_THIS_AGENT 8'h00
`define PBE_UM_ALL_AGENTS 8'h20

// ==================================================
// sizes and timing
`define PBE_LINE_W 26
`define PBE_PF_SLOTS 4
`define PBE_PEND_W 5
`define PBE_HOLDOFF_CYC 2'h2
`define PBE_HOLDOFF_LEVEL 5'h0c

`endif

/* File: pkg/pbe_pkg.sv */
// types shared by the prefetch/bus event counter
`include "pbe_defines.svh"
package pbe_pkg;
    typedef enum logic [2:0] {
        PBE_RD_L1D = 3'h0,
        PBE_RD_L2PF = 3'h1,
        PBE_RD_OWN = 3'h2,
        PBE_RD_IFETCH = 3'h3,
        PBE_TR_OTHER = 3'h4
    } pbe_tr_kind_t;

    typedef enum logic [1:0] {
        PBE_PF_ALL = 2'h0,
        PBE_PF_OUTER_A = 2'h1,
        PBE_PF_OUTER_B = 2'h2,
        PBE_PF_NONE = 2'h3
    } pbe_pf_kind_t;

    typedef struct packed {
        logic [`PBE_PF_SLOTS-1:0] valid;
        logic [`PBE_PF_SLOTS-1:0][`PBE_LINE_W-1:0] line;
        logic loadHit;
    } pbe_trk_st_t;

    typedef struct packed {
        logic issue1, issue2;
        logic [2:0] issueKind1, issueKind2;
        logic done1, done2;
        logic [2:0] doneKind1, doneKind2;
        logic dvIn1, dvIn2;
        logic holdIn1, holdIn2;
        logic [`PBE_PEND_W-1:0] pend;
        logic [1:0] holdCnt;
        logic holdRise;
        logic ownDrive;
        logic [`PBE_PEND_W-1:0] pendOcc;
    } pbe_bus_st_t;

    typedef struct packed {
        logic [16:0] ctrl;
        logic [31:0] count;
        logic ack;
        logic [31:0] rdata;
    } pbe_top_st_t;
endpackage

/* File: pkg/pbe_evt_if.sv */
// occurrence signals passed from the detector modules to the counter
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defines.svh"
interface pbe_evt_if;
    logic loadHitPf;
    logic [`PBE_PEND_W-1:0] pendOcc;
    logic notReadyRise;
    logic dvOwn;
    logic dvAny;
    logic [`PBE_PEND_W-1:0] pendNow;
    logic holdOffOut;

    modport trk (output loadHitPf);
    modport bus (output pendOcc, notReadyRise, dvOwn, dvAny, pendNow, holdOffOut);
    modport cnt (input loadHitPf, pendOcc, notReadyRise, dvOwn, dvAny, pendNow, holdOffOut);
endinterface
`default_nettype wire

/* File: rtl/pbe_pf_track.sv */
// in-flight software prefetch tracker; flags loads that hit a line still being prefetched
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defines.svh"
module pbe_pf_track
    import pbe_pkg::*;
#(
    parameter int SLOTS = `PBE_PF_SLOTS
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic pfStart,
    input wire logic [`PBE_LINE_W-1:0] pfStartLine,
    input wire logic pfDone,
    input wire logic [`PBE_LINE_W-1:0] pfDoneLine,
    input wire logic loadIssue,
    input wire logic [`PBE_LINE_W-1:0] loadLine,
    pbe_evt_if.trk evt
);
    if (SLOTS < 1 || SLOTS > `PBE_PF_SLOTS) begin : g_chk
        $error("pbe_pf_track: SLOTS out of range");
    end

    pbe_trk_st_t st_ff, nxt_st;
    logic placed;

    // ==================================================
    // slot bookkeeping
    always_comb begin
        nxt_st = st_ff;
        placed = 1'b0;
        nxt_st.loadHit = 1'b0;
        // a load is compared against slots as they stand, so one that meets the start cycle is not flagged
        for (int i = 0; i < SLOTS; i++) begin
            if (loadIssue && st_ff.valid[i] && st_ff.line[i] == loadLine) begin
                nxt_st.loadHit = 1'b1; // RQ4
            end
        end
        for (int i = 0; i < SLOTS; i++) begin
            if (pfDone && st_ff.valid[i] && st_ff.line[i] == pfDoneLine) begin
                nxt_st.valid[i] = 1'b0;
            end
        end
        // when every slot is busy the newest prefetch goes untracked
        for (int i = 0; i < SLOTS; i++) begin
            if (pfStart && !placed && !nxt_st.valid[i]) begin
                nxt_st.valid[i] = 1'b1;
                nxt_st.line[i] = pfStartLine;
                placed = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign evt.loadHitPf = st_ff.loadHit;
endmodule
`default_nettype wire

/* File: rtl/pbe_bus_mon.sv */
// system bus monitor: pending line reads, hold-off drive and data-valid cycles
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defines.svh"
module pbe_bus_mon
    import pbe_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic busIssue,
    input wire logic [2:0] busIssueKind,
    input wire logic busLineDone,
    input wire logic [2:0] busDoneKind,
    input wire logic dataValidIn,
    input wire logic holdOffIn,
    input wire logic [`PBE_PEND_W-1:0] snoopPend,
    input wire logic ownDataXfer,
    output logic dataValidOut,
    output logic holdOffOut,
    output logic issueOk,
    pbe_evt_if.bus evt
);
    pbe_bus_st_t st_ff, nxt_st;
    logic [`PBE_PEND_W:0] load;

    function automatic logic countedRead(input logic [2:0] k);
        countedRead = (k == PBE_RD_L1D) || (k == PBE_RD_L2PF); // RQ9
    endfunction

    // ==================================================
    // pin synchronisers and counters
    always_comb begin
        nxt_st = st_ff;
        nxt_st.issue1 = busIssue;
        nxt_st.issue2 = st_ff.issue1;
        nxt_st.issueKind1 = busIssueKind;
        nxt_st.issueKind2 = st_ff.issueKind1;
        nxt_st.done1 = busLineDone;
        nxt_st.done2 = st_ff.done1;
        nxt_st.doneKind1 = busDoneKind;
        nxt_st.doneKind2 = st_ff.doneKind1;
        nxt_st.dvIn1 = dataValidIn;
        nxt_st.dvIn2 = st_ff.dvIn1;
        nxt_st.holdIn1 = holdOffIn;
        nxt_st.holdIn2 = st_ff.holdIn1;
        // a read is pending from its issue cycle through the cycle its last chunk lands
        nxt_st.pendOcc = st_ff.pend + (`PBE_PEND_W)'(st_ff.issue2 && countedRead(st_ff.issueKind2)); // RQ8
        nxt_st.pend = st_ff.pend
            + (`PBE_PEND_W)'(st_ff.issue2 && countedRead(st_ff.issueKind2))
            - (`PBE_PEND_W)'(st_ff.done2 && countedRead(st_ff.doneKind2) && st_ff.pend != '0);
        nxt_st.holdRise = 1'b0;
        load = {1'b0, st_ff.pend} + {1'b0, snoopPend};
        if (st_ff.holdCnt != 2'h0) begin
            nxt_st.holdCnt = st_ff.holdCnt - 2'h1;
        end else if (load >= {1'b0, `PBE_HOLDOFF_LEVEL}) begin
            nxt_st.holdCnt = `PBE_HOLDOFF_CYC; // RQ11 RQ12
            nxt_st.holdRise = 1'b1; // RQ10
        end
        nxt_st.ownDrive = ownDataXfer; // RQ15
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign holdOffOut = st_ff.holdCnt != 2'h0;
    assign issueOk = !(holdOffOut || st_ff.holdIn2); // RQ13
    assign dataValidOut = st_ff.ownDrive;
    assign evt.pendOcc = st_ff.pendOcc; // RQ7
    assign evt.notReadyRise = st_ff.holdRise;
    assign evt.dvOwn = st_ff.ownDrive; // RQ16
    assign evt.dvAny = st_ff.dvIn2; // RQ17
    assign evt.pendNow = st_ff.pend;
    assign evt.holdOffOut = holdOffOut;
endmodule
`default_nettype wire

/* File: tb/pbe_bus_agent.sv */
// behavioural model of the other bus agents sharing the data-valid and hold-off wires
`timescale 1ns/1ns
`default_nettype none
module pbe_bus_agent (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ownDv,
    input wire logic ownHold,
    input wire logic xferGo,
    input wire logic [3:0] xferLen,
    input wire logic busyReq,
    output logic dataValidIn,
    output logic holdOffIn
);
    logic [3:0] left_ff;
    logic [1:0] hold_ff;
    logic pend_ff;
    // ==========================================
    // transfers wait out our hold-off before starting
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            left_ff <= 4'h0;
            hold_ff <= 2'h0;
            pend_ff <= 1'h0;
        end else begin
            if (xferGo)
                pend_ff <= 1'h1;
            if ((pend_ff || xferGo) && !ownHold && left_ff == 4'h0) begin
                left_ff <= xferLen;
                pend_ff <= 1'h0;
            end else if (left_ff != 4'h0)
                left_ff <= left_ff - 4'h1;
            if (busyReq && hold_ff == 2'h0)
                hold_ff <= 2'h2;
            else if (hold_ff != 2'h0)
                hold_ff <= hold_ff - 2'h1;
        end
    end
    // wire level: any driver raises the strobe
    assign dataValidIn = ownDv | (left_ff != 4'h0);
    assign holdOffIn = hold_ff != 2'h0;
endmodule
`default_nettype wire

/* File: tb/pbe_event_count_checker.sv */
// concurrent checks on the event counter's ports
`timescale 1ns/1ns
`default_nettype none
module pbe_event_count_checker (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic l1PfReq,
    input wire logic l2Busy,
    input wire logic l1PfAccept,
    input wire logic coreBusReq,
    input wire logic busReqGo,
    input wire logic ownDataXfer,
    input wire logic dataValidOut,
    input wire logic holdOffOut
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ==========================================
    // register bus
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("first request cycle not stalled");
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait state");
    idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high while idle");
    unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'hc |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    ctrl_upper_a: assert property (avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[31:17] == 15'h0)
        else $error("control upper bits not zero");
    // ==========================================
    // core and bus side
    pf_accept_a: assert property (l1PfAccept == (l1PfReq && !l2Busy))
        else $error("prefetch accept wrong");
    dv_own_a: assert property (ownDataXfer |=> dataValidOut)
        else $error("strobe missing for own transfer");
    dv_quiet_a: assert property (!ownDataXfer |=> !dataValidOut)
        else $error("strobe without own transfer");
    hold_len_a: assert property ($rose(holdOffOut) |-> holdOffOut ##1 holdOffOut ##1 !holdOffOut)
        else $error("hold-off not two cycles");
    go_gate_a: assert property (busReqGo |-> coreBusReq && !holdOffOut)
        else $error("issue allowed during hold-off");
endmodule
bind pbe_event_count pbe_event_count_checker u_pbe_event_count_checker (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .l1PfReq(l1PfReq), .l2Busy(l2Busy), .l1PfAccept(l1PfAccept),
    .coreBusReq(coreBusReq), .busReqGo(busReqGo), .ownDataXfer(ownDataXfer), .dataValidOut(dataValidOut),
    .holdOffOut(holdOffOut));
`default_nettype wire

/* File: tb/pbe_event_count_tb.sv */
// self-checking bench for the prefetch/bus event counter
`timescale 1ns/1ns
`default_nettype none
`include "pbe_defines.svh"
module pbe_event_count_tb;
    logic ref_clk = 1'h0, nrst = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, xferLen = 4'h2;
    logic [31:0] avs_writedata = 32'h0, rv;
    wire logic [31:0] avs_readdata;
    wire logic avs_waitrequest, l1PfAccept, busReqGo, dataValidIn, holdOffIn, dataValidOut, holdOffOut;
    logic pfExec = 1'h0, pfMissAll = 1'h0, pfStart = 1'h0, pfDone = 1'h0, loadIssue = 1'h0, l1PfReq = 1'h0;
    logic l2Busy = 1'h0, coreBusReq = 1'h0, busIssue = 1'h0, busLineDone = 1'h0, ownDataXfer = 1'h0;
    logic xferGo = 1'h0, busyReq = 1'h0;
    logic [1:0] pfKind = 2'h0;
    logic [`PBE_LINE_W-1:0] pfStartLine = '0, pfDoneLine = '0, loadLine = '0;
    logic [2:0] busIssueKind = 3'h0, busDoneKind = 3'h0;
    logic [`PBE_PEND_W-1:0] snoopPend = '0;
    logic [2:0] pfTab [6] = '{3'h1, 3'h3, 3'h5, 3'h0, 3'h7, 3'h1};
    logic [7:0] ums [3] = '{8'h01, 8'h02, 8'h03};
    logic [31:0] pfExp [3] = '{32'h2, 32'h2, 32'h0};
    int err_count = 0, cmp_count = 0, hiCyc = 0;

    pbe_event_count u_pbe_event_count (.ref_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .pfExec, .pfKind, .pfMissAll, .pfStart, .pfStartLine,
        .pfDone, .pfDoneLine, .loadIssue, .loadLine, .l1PfReq, .l2Busy, .l1PfAccept, .coreBusReq, .busReqGo,
        .busIssue, .busIssueKind, .busLineDone, .busDoneKind, .dataValidIn, .holdOffIn, .snoopPend,
        .ownDataXfer, .dataValidOut, .holdOffOut);
    pbe_bus_agent u_pbe_bus_agent (.ref_clk, .nrst, .ownDv(dataValidOut), .ownHold(holdOffOut), .xferGo,
        .xferLen, .busyReq, .dataValidIn, .holdOffIn);

    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (holdOffOut === 1'h1) hiCyc <= hiCyc + 1;

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // ==========================================
    // one Avalon access; read data taken at the rising edge where waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'h0 && n < 100);
        if (n >= 100) begin
            err_count++;
            test_done();
        end
        rv = avs_readdata;
        avs_read <= 1'h0;
        avs_write <= 1'h0;
    endtask
    task automatic sel(input logic [7:0] code, input logic [7:0] mask);
        bus(1'h1, `PBE_OFS_COUNT, 32'h0);
        bus(1'h1, `PBE_OFS_CTRL, {15'h0, 1'h1, mask, code});
    endtask
    // six cycles covers the three-cycle bus pin path
    task automatic getc();
        repeat (6) @(posedge ref_clk);
        bus(1'h0, `PBE_OFS_COUNT, 32'h0);
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        nrst <= 1'h1;
        for (int a = 0; a < 16; a += 4) begin
            bus(1'h0, a[3:0], 32'h0);
            chk(rv, 32'h0);
        end
        bus(1'h1, `PBE_OFS_CTRL, 32'hffffffff);
        bus(1'h0, `PBE_OFS_CTRL, 32'h0);
        chk(rv, 32'h0001ffff);
        avs_byteenable <= 4'h2;
        bus(1'h1, `PBE_OFS_CTRL, 32'h00003c00);
        avs_byteenable <= 4'hf;
        bus(1'h0, `PBE_OFS_CTRL, 32'h0);
        chk(rv, 32'h00013cff);
        $display("test registers done");
        for (int u = 0; u < 3; u++) begin
            sel(`PBE_EV_PF_MISS, ums[u]);
            for (int i = 0; i < 6; i++) begin
                @(posedge ref_clk);
                pfExec <= 1'h1;
                pfKind <= pfTab[i][2:1];
                pfMissAll <= pfTab[i][0];
            end
            @(posedge ref_clk);
            pfExec <= 1'h0;
            getc();
            chk(rv, pfExp[u]);
        end
        $display("test prefetch miss done");
        sel(`PBE_EV_LOAD_HIT_PF, `PBE_UM_LOAD_HIT_PF);
        @(posedge ref_clk);
        pfStart <= 1'h1;
        pfStartLine <= 26'h0000123;
        @(posedge ref_clk);
        pfStart <= 1'h0;
        loadIssue <= 1'h1;
        loadLine <= 26'h0000123;
        @(posedge ref_clk);
        loadLine <= 26'h0000456;
        @(posedge ref_clk);
        loadIssue <= 1'h0;
        pfDone <= 1'h1;
        pfDoneLine <= 26'h0000123;
        @(posedge ref_clk);
        pfDone <= 1'h0;
        loadIssue <= 1'h1;
        loadLine <= 26'h0000123;
        @(posedge ref_clk);
        loadIssue <= 1'h0;
        getc();
        chk(rv, 32'h1);
        sel(`PBE_EV_L1_PF_REQ, `PBE_UM_L1_PF_REQ);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            l1PfReq <= 1'h1;
            l2Busy <= (i == 1);
        end
        @(posedge ref_clk);
        l1PfReq <= 1'h0;
        l2Busy <= 1'h0;
        getc();
        chk(rv, 32'h3);
        $display("test cache events done");
        sel(`PBE_EV_RD_PEND, `PBE_UM_THIS_AGENT);
        for (int k = 0; k < 5; k++) begin
            @(posedge ref_clk);
            busIssue <= 1'h1;
            busIssueKind <= k[2:0];
            @(posedge ref_clk);
            busIssue <= 1'h0;
            repeat (3) @(posedge ref_clk);
            busLineDone <= 1'h1;
            busDoneKind <= k[2:0];
            @(posedge ref_clk);
            busLineDone <= 1'h0;
        end
        getc();
        chk(rv, 32'ha);
        sel(`PBE_EV_NOT_READY, `PBE_UM_THIS_AGENT);
        @(posedge ref_clk);
        snoopPend <= `PBE_HOLDOFF_LEVEL;
        coreBusReq <= 1'h1;
        busyReq <= 1'h1;
        repeat (10) @(posedge ref_clk);
        snoopPend <= '0;
        busyReq <= 1'h0;
        getc();
        coreBusReq <= 1'h0;
        chk(32'(hiCyc), rv << 1);
        chk({31'h0, rv == 32'h0}, 32'h0);
        for (int u = 0; u < 2; u++) begin
            sel(`PBE_EV_DATA_VALID, u ? `PBE_UM_ALL_AGENTS : `PBE_UM_THIS_AGENT);
            @(posedge ref_clk);
            ownDataXfer <= 1'h1;
            repeat (3) @(posedge ref_clk);
            ownDataXfer <= 1'h0;
            repeat (4) @(posedge ref_clk);
            xferGo <= 1'h1;
            @(posedge ref_clk);
            xferGo <= 1'h0;
            getc();
            chk(rv, u ? 32'h5 : 32'h3);
        end
        $display("test bus events done");
        test_done();
    end
endmodule
`default_nettype wire
